// ==== rtl/ipfs_params.svh ====
// constants for the input pin function select block: offsets, fields, resets
// assumes an 8-bit register port with page 0 addressing handled upstream
// What this block does
// - bidir pin level shown in monitor bit 7
// - bidir monitor at 0x2A, read-only, reset zero
// - pin 1 function from config a bits 6-4
// - codes 4-7 route pdm data pairs
// - code 0 disables pin and monitor
// - pin 2 function from config a bits 2-0
// - pin 3 function from config b bits 6-4
// - pin 4 function from config b bits 2-0
// - config a at 0x2B, resets to zero
// - config b at 0x2C, resets to zero
// - input monitor at 0x2F, resets to zero
// - input monitor bits 7-4 show pins 1-4
`ifndef IPFS_PARAMS_SVH
`define IPFS_PARAMS_SVH
// ****************************************************************
// register offsets
// ****************************************************************
`define IPFS_ADDR_BIDIR_MON  8'h2A
`define IPFS_ADDR_CFG_A      8'h2B
`define IPFS_ADDR_CFG_B      8'h2C
`define IPFS_ADDR_IN_MON     8'h2F
// ****************************************************************
// field positions and reset values
// ****************************************************************
`define IPFS_HI_FIELD_LSB    4
`define IPFS_LO_FIELD_LSB    0
`define IPFS_BIDIR_BIT       7
`define IPFS_IN_MON_LSB      4
`define IPFS_CFG_WMASK       8'h77
`define IPFS_RESET_VAL       8'h00
`endif

// ==== rtl/ipfs_pkg.sv ====
// types for the input pin function select block
// assumes ipfs_params.svh supplies the numeric constants
package ipfs_pkg;
    // function codes of each input pin field
    typedef enum logic [2:0] {
        IPFS_FN_OFF   = 3'h0,
        IPFS_FN_GPI   = 3'h1,
        IPFS_FN_MCLK  = 3'h2,
        IPFS_FN_CHAIN = 3'h3,
        IPFS_FN_PDM12 = 3'h4,
        IPFS_FN_PDM34 = 3'h5,
        IPFS_FN_PDM56 = 3'h6,
        IPFS_FN_PDM78 = 3'h7
    } ipfs_func_e;
    // register port request
    typedef struct packed {
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ipfs_req_s;
    // routed internal functions
    typedef struct packed {
        logic       mclk;
        logic       mclk_valid;
        logic       chain_serial_input;
        logic       chain_valid;
        logic [3:0] density_data;
        logic [3:0] density_valid;
    } ipfs_route_s;
endpackage

// ==== rtl/ipfs_top.sv ====
// input pin function select: config registers, routing and level monitors
// assumes the control port decoder hands over page 0 accesses, one per cycle
`timescale 1ns/1ps
`default_nettype none
`include "ipfs_params.svh"
module ipfs_top (
    input  wire logic                i_clock,
    input  wire logic                i_rst,
    input  wire ipfs_pkg::ipfs_req_s i_req,
    input  wire logic                i_input_pin_one,
    input  wire logic                i_input_pin_two,
    input  wire logic                i_input_pin_three,
    input  wire logic                i_input_pin_four,
    input  wire logic                i_bidir_pin_in,
    input  wire logic                i_bidir_is_input,
    output logic [7:0]               o_rdata,
    output ipfs_pkg::ipfs_route_s    o_route
);
    import ipfs_pkg::*;
    // ****************************************************************
    // registers
    // ****************************************************************
    logic [7:0] input_pin_config_a;   // pins 1 and 2 functions
    logic [7:0] input_pin_config_b;   // pins 3 and 4 functions
    logic [3:0] pin_meta;             // first sync stage, read only by pin_sync
    logic [3:0] pin_sync;             // second sync stage
    logic       bidir_meta;           // first sync stage of bidir pin
    logic       bidir_sync;           // second sync stage of bidir pin
    logic [3:0] in_level;             // monitor bits for pins 1..4
    logic       bidir_pin1_level;     // monitor bit of bidir pin
    // ****************************************************************
    // decode
    // ****************************************************************
    wire [3:0]  pins = {i_input_pin_four, i_input_pin_three,
                        i_input_pin_two, i_input_pin_one};
    wire [2:0]  in_pin1_function = input_pin_config_a[`IPFS_HI_FIELD_LSB +: 3];
    wire [2:0]  in_pin2_function = input_pin_config_a[`IPFS_LO_FIELD_LSB +: 3];
    wire [2:0]  in_pin3_function = input_pin_config_b[`IPFS_HI_FIELD_LSB +: 3];
    wire [2:0]  in_pin4_function = input_pin_config_b[`IPFS_LO_FIELD_LSB +: 3];
    wire [11:0] funcs = {in_pin4_function, in_pin3_function,
                         in_pin2_function, in_pin1_function};
    wire        wr_a = i_req.wr && (i_req.addr == `IPFS_ADDR_CFG_A);
    wire        wr_b = i_req.wr && (i_req.addr == `IPFS_ADDR_CFG_B);
    wire [7:0]  bidir_pin_monitor = {bidir_pin1_level, 7'h00};
    wire [7:0]  input_pin_monitor = {in_level, 4'h0};
    // read mux; unmapped addresses read zero
    wire [7:0]  next_rdata =
        (i_req.addr == `IPFS_ADDR_BIDIR_MON) ? bidir_pin_monitor :
        (i_req.addr == `IPFS_ADDR_CFG_A)     ? input_pin_config_a :
        (i_req.addr == `IPFS_ADDR_CFG_B)     ? input_pin_config_b :
        (i_req.addr == `IPFS_ADDR_IN_MON)    ? input_pin_monitor :
        8'h00;
    // ****************************************************************
    // routing: lowest numbered pin wins a shared function
    // ****************************************************************
    ipfs_route_s next_route;
    always_comb begin
        next_route = '0;
        // walk from pin 4 down so pin 1 overwrites last
        for (int p = 3; p >= 0; p--) begin
            case (ipfs_func_e'(funcs[p*3 +: 3]))
                IPFS_FN_MCLK: begin
                    next_route.mclk       = pin_sync[p];
                    next_route.mclk_valid = 1'b1;
                end
                IPFS_FN_CHAIN: begin
                    next_route.chain_serial_input = pin_sync[p];
                    next_route.chain_valid        = 1'b1;
                end
                IPFS_FN_PDM12, IPFS_FN_PDM34, IPFS_FN_PDM56, IPFS_FN_PDM78: begin
                    next_route.density_data[funcs[p*3 +: 2]]  = pin_sync[p];
                    next_route.density_valid[funcs[p*3 +: 2]] = 1'b1;
                end
                default: begin
                    // off or general input drives nothing internal
                end
            endcase
        end
    end
    // ****************************************************************
    // routing checks
    // ****************************************************************
    // pin 1 as master clock drives the clock route one cycle later
    property p_pin1_mclk;
        @(posedge i_clock) disable iff (i_rst)
        in_pin1_function == 3'h2 |=> o_route.mclk_valid && o_route.mclk == $past(pin_sync[0]);
    endproperty
    a_pin1_mclk: assert property (p_pin1_mclk) else $error("pin1 mclk route");
    // code 5 on pin 1 claims pair 3-4, which nothing can take from it
    property p_pdm;
        @(posedge i_clock) disable iff (i_rst)
        in_pin1_function == 3'h5 |=> o_route.density_valid[1];
    endproperty
    a_pdm: assert property (p_pdm) else $error("pdm pair route");
    // pin 3 owns the chain input when neither lower pin claims it
    property p_pin3_chain;
        @(posedge i_clock) disable iff (i_rst)
        in_pin3_function == IPFS_FN_CHAIN && in_pin2_function != IPFS_FN_CHAIN
            && in_pin1_function != IPFS_FN_CHAIN
            |=> o_route.chain_valid && o_route.chain_serial_input == $past(pin_sync[2]);
    endproperty
    a_pin3_chain: assert property (p_pin3_chain) else $error("pin3 chain route");
    // pin 2 on code 4 feeds pair 1-2 unless pin 1 also asks for it
    property p_pin2_pdm12;
        @(posedge i_clock) disable iff (i_rst)
        in_pin2_function == IPFS_FN_PDM12 && in_pin1_function != IPFS_FN_PDM12
            |=> o_route.density_valid[0] && o_route.density_data[0] == $past(pin_sync[1]);
    endproperty
    a_pin2_pdm12: assert property (p_pin2_pdm12) else $error("pin2 pdm route");
    // two pins on one pair: the lower numbered one is heard
    property p_lowest_pdm;
        @(posedge i_clock) disable iff (i_rst)
        in_pin3_function == IPFS_FN_PDM78 && in_pin4_function == IPFS_FN_PDM78
            && in_pin1_function != IPFS_FN_PDM78 && in_pin2_function != IPFS_FN_PDM78
            |=> o_route.density_data[3] == $past(pin_sync[2]);
    endproperty
    a_lowest_pdm: assert property (p_lowest_pdm) else $error("shared pair owner");
    // no pin asks for the master clock, so its route stays invalid
    property p_no_mclk;
        @(posedge i_clock) disable iff (i_rst)
        in_pin1_function != IPFS_FN_MCLK && in_pin2_function != IPFS_FN_MCLK
            && in_pin3_function != IPFS_FN_MCLK && in_pin4_function != IPFS_FN_MCLK
            |=> !o_route.mclk_valid;
    endproperty
    a_no_mclk: assert property (p_no_mclk) else $error("stray mclk route");
    // all pins disabled: nothing internal is driven
    property p_all_off;
        @(posedge i_clock) disable iff (i_rst)
        funcs == 12'h000 |=> o_route == '0;
    endproperty
    a_all_off: assert property (p_all_off) else $error("route while disabled");
    // ****************************************************************
    // config writes; reserved bits stay zero
    // ****************************************************************
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            input_pin_config_a <= `IPFS_RESET_VAL;
            input_pin_config_b <= `IPFS_RESET_VAL;
        end else begin
            if (wr_a) begin
                input_pin_config_a <= i_req.wdata & `IPFS_CFG_WMASK;
            end
            if (wr_b) begin
                input_pin_config_b <= i_req.wdata & `IPFS_CFG_WMASK;
            end
        end
    end
    // ****************************************************************
    // config register checks
    // ****************************************************************
    // a write to config a lands masked on the next edge
    property p_cfg_a;
        @(posedge i_clock) disable iff (i_rst)
        wr_a |=> input_pin_config_a == ($past(i_req.wdata) & `IPFS_CFG_WMASK);
    endproperty
    a_cfg_a: assert property (p_cfg_a) else $error("config a write");
    // a write to config b lands masked on the next edge
    property p_cfg_b;
        @(posedge i_clock) disable iff (i_rst)
        wr_b |=> input_pin_config_b == ($past(i_req.wdata) & `IPFS_CFG_WMASK);
    endproperty
    a_cfg_b: assert property (p_cfg_b) else $error("config b write");
    // reserved bits of config a never hold a one
    property p_cfg_a_res;
        @(posedge i_clock) disable iff (i_rst)
        (input_pin_config_a & ~`IPFS_CFG_WMASK) == 8'h00;
    endproperty
    a_cfg_a_res: assert property (p_cfg_a_res) else $error("config a reserved set");
    // reserved bits of config b never hold a one
    property p_cfg_b_res;
        @(posedge i_clock) disable iff (i_rst)
        (input_pin_config_b & ~`IPFS_CFG_WMASK) == 8'h00;
    endproperty
    a_cfg_b_res: assert property (p_cfg_b_res) else $error("config b reserved set");
    // without a write to its address config a holds
    property p_cfg_a_hold;
        @(posedge i_clock) disable iff (i_rst)
        !wr_a |=> $stable(input_pin_config_a);
    endproperty
    a_cfg_a_hold: assert property (p_cfg_a_hold) else $error("config a moved");
    // without a write to its address config b holds
    property p_cfg_b_hold;
        @(posedge i_clock) disable iff (i_rst)
        !wr_b |=> $stable(input_pin_config_b);
    endproperty
    a_cfg_b_hold: assert property (p_cfg_b_hold) else $error("config b moved");
    // ****************************************************************
    // synchronisers; raw pins may be asynchronous in practice
    // ****************************************************************
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            pin_meta   <= 4'h0;
            pin_sync   <= 4'h0;
            bidir_meta <= 1'b0;
            bidir_sync <= 1'b0;
        end else begin
            pin_meta   <= pins;
            pin_sync   <= pin_meta;
            bidir_meta <= i_bidir_pin_in;
            bidir_sync <= bidir_meta;
        end
    end
    // ****************************************************************
    // monitors: update only in general input mode, else hold
    // ****************************************************************
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            in_level         <= 4'h0;
            bidir_pin1_level <= 1'b0;
        end else begin
            for (int p = 0; p < 4; p++) begin
                if (funcs[p*3 +: 3] == IPFS_FN_GPI) begin
                    in_level[3-p] <= pin_sync[p];
                end
            end
            if (i_bidir_is_input) begin
                bidir_pin1_level <= bidir_sync;
            end
        end
    end
    // ****************************************************************
    // monitor checks
    // ****************************************************************
    // bidir pin in input mode copies its synchronised level
    property p_bidir_level;
        @(posedge i_clock) disable iff (i_rst)
        i_bidir_is_input ##1 1'b1 |-> bidir_pin1_level == $past(bidir_sync);
    endproperty
    a_bidir_level: assert property (p_bidir_level) else $error("bidir level wrong");
    // pin 1 not a general input: its monitor bit holds
    property p_off;
        @(posedge i_clock) disable iff (i_rst)
        in_pin1_function != 3'h1 |=> $stable(in_level[3]);
    endproperty
    a_off: assert property (p_off) else $error("monitor moved");
    // bidir pin out of input mode keeps its last monitored level
    property p_bidir_hold;
        @(posedge i_clock) disable iff (i_rst)
        !i_bidir_is_input |=> $stable(bidir_pin1_level);
    endproperty
    a_bidir_hold: assert property (p_bidir_hold) else $error("bidir level moved");
    // pin 1 as general input lands in the top monitor bit
    property p_pin1_gpi;
        @(posedge i_clock) disable iff (i_rst)
        in_pin1_function == IPFS_FN_GPI |=> in_level[3] == $past(pin_sync[0]);
    endproperty
    a_pin1_gpi: assert property (p_pin1_gpi) else $error("pin1 level wrong");
    // pin 4 as general input lands in the lowest monitor bit
    property p_pin4_gpi;
        @(posedge i_clock) disable iff (i_rst)
        in_pin4_function == IPFS_FN_GPI |=> in_level[0] == $past(pin_sync[3]);
    endproperty
    a_pin4_gpi: assert property (p_pin4_gpi) else $error("pin4 level wrong");
    // pin 2 not a general input: its monitor bit holds
    property p_pin2_hold;
        @(posedge i_clock) disable iff (i_rst)
        in_pin2_function != IPFS_FN_GPI |=> $stable(in_level[2]);
    endproperty
    a_pin2_hold: assert property (p_pin2_hold) else $error("pin2 level moved");
    // ****************************************************************
    // outputs, registered
    // ****************************************************************
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_rdata <= 8'h00;
            o_route <= '0;
        end else begin
            o_rdata <= next_rdata;
            o_route <= next_route;
        end
    end
    // ****************************************************************
    // read port checks
    // ****************************************************************
    // reserved bits of the bidir monitor always read zero
    property p_bidir_rd;
        @(posedge i_clock) disable iff (i_rst)
        i_req.addr == `IPFS_ADDR_BIDIR_MON |=> o_rdata[6:0] == 7'h00;
    endproperty
    a_bidir_rd: assert property (p_bidir_rd) else $error("bidir reserved nonzero");
    // input monitor reads the held levels over a zero low nibble
    property p_mon_rd;
        @(posedge i_clock) disable iff (i_rst)
        i_req.addr == `IPFS_ADDR_IN_MON |=> o_rdata == {$past(in_level), 4'h0};
    endproperty
    a_mon_rd: assert property (p_mon_rd) else $error("input monitor read");
    // config a reads back what it holds
    property p_cfg_rd_a;
        @(posedge i_clock) disable iff (i_rst)
        i_req.addr == `IPFS_ADDR_CFG_A |=> o_rdata == $past(input_pin_config_a);
    endproperty
    a_cfg_rd_a: assert property (p_cfg_rd_a) else $error("config a read");
    // config b reads back what it holds
    property p_cfg_rd_b;
        @(posedge i_clock) disable iff (i_rst)
        i_req.addr == `IPFS_ADDR_CFG_B |=> o_rdata == $past(input_pin_config_b);
    endproperty
    a_cfg_rd_b: assert property (p_cfg_rd_b) else $error("config b read");
    // any other address reads zero, so stray reads show nothing stale
    property p_unmapped_rd;
        @(posedge i_clock) disable iff (i_rst)
        i_req.addr != `IPFS_ADDR_BIDIR_MON && i_req.addr != `IPFS_ADDR_CFG_A
            && i_req.addr != `IPFS_ADDR_CFG_B && i_req.addr != `IPFS_ADDR_IN_MON
            |=> o_rdata == 8'h00;
    endproperty
    a_unmapped_rd: assert property (p_unmapped_rd) else $error("unmapped read");
    // bidir monitor top bit carries the held bidir level
    property p_bidir_mon_rd;
        @(posedge i_clock) disable iff (i_rst)
        i_req.addr == `IPFS_ADDR_BIDIR_MON |=> o_rdata[7] == $past(bidir_pin1_level);
    endproperty
    a_bidir_mon_rd: assert property (p_bidir_mon_rd) else $error("bidir level read");
endmodule
`default_nettype wire

// ==== testbench/ipfs_top_test.sv ====
// self-checking bench for the input pin function select block
// assumes ipfs_top with page 0 register port, read data registered one cycle
`timescale 1ns/1ps
`default_nettype none
`include "ipfs_params.svh"
module ipfs_top_test;
    import ipfs_pkg::*;
    logic              i_clock;   // 250 MHz
    logic              i_rst;     // sync, active high
    ipfs_req_s         req;       // register port request
    logic [3:0]        pins;      // bit 0 is pin one
    logic              bidir;     // bidir pin level
    logic              bidir_in;  // bidir pin set as general input
    logic [7:0]        rdata;     // read data
    ipfs_route_s       route;     // routed functions
    int                fails;     // mismatch counter
    int                num_checks; // comparison counter
    int                cfg_a;     // model config a
    int                cfg_b;     // model config b
    bit [3:0]          lvl;       // model held input levels
    bit                blvl;      // model held bidir level
    ipfs_top dut (.i_clock(i_clock), .i_rst(i_rst), .i_req(req),
        .i_input_pin_one(pins[0]), .i_input_pin_two(pins[1]),
        .i_input_pin_three(pins[2]), .i_input_pin_four(pins[3]),
        .i_bidir_pin_in(bidir), .i_bidir_is_input(bidir_in),
        .o_rdata(rdata), .o_route(route));
    // ****************************************************************
    // clock and shared tasks
    // ****************************************************************
    initial begin
        i_clock = 1'b0;
        forever #2 i_clock = ~i_clock;
    end
    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_route(input ipfs_route_s got, input ipfs_route_s exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one write cycle; the strobe stays up so a second write can follow
    // back to back, and the caller lowers it after the last write
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        req = '{wr: 1'b1, addr: a, wdata: d};
        @(negedge i_clock);
    endtask
    // address is sampled at the next rising edge, data stands after it
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        req = '{wr: 1'b0, addr: a, wdata: 8'h00};
        @(negedge i_clock);
        d = rdata;
    endtask
    function automatic int fcode(input int p);
        int r;
        r = (p < 2) ? cfg_a : cfg_b;
        return (p % 2 == 0) ? ((r >> 4) & 7) : (r & 7);
    endfunction
    // model: lowest pin wins, so walk from pin four down and overwrite
    task automatic check_all();
        ipfs_route_s exp;
        ipfs_route_s got;
        logic [7:0]  d;
        int          c;
        exp = '0;
        for (int p = 3; p >= 0; p--) begin
            c = fcode(p);
            if (c == 1) lvl[p] = pins[p];
            if (c == 2) {exp.mclk_valid, exp.mclk} = {1'b1, pins[p]};
            if (c == 3) {exp.chain_valid, exp.chain_serial_input} = {1'b1, pins[p]};
            if (c >= 4) {exp.density_valid[c-4], exp.density_data[c-4]} = {1'b1, pins[p]};
        end
        if (bidir_in) blvl = bidir;
        got = route;
        // data lines carry no meaning while their valid is low
        got.mclk &= got.mclk_valid;
        got.chain_serial_input &= got.chain_valid;
        got.density_data &= got.density_valid;
        chk_route(got, exp);
        rd(`IPFS_ADDR_IN_MON, d);
        chk8(d, {lvl[0], lvl[1], lvl[2], lvl[3], 4'h0});
        rd(`IPFS_ADDR_BIDIR_MON, d);
        chk8(d, {blvl, 7'h00});
        rd(`IPFS_ADDR_CFG_A, d);
        chk8(d, cfg_a[7:0]);
        rd(`IPFS_ADDR_CFG_B, d);
        chk8(d, cfg_b[7:0]);
        rd(8'h2D, d);
        chk8(d, 8'h00);
    endtask
    task automatic do_reset();
        i_rst = 1'b1;
        bidir_in = 1'b0;  // monitor must show its reset value right after
        repeat (8) @(negedge i_clock);
        i_rst = 1'b0;
        {cfg_a, cfg_b, lvl, blvl} = '0;
    endtask
    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        {fails, num_checks} = '0;
        req = '0;
        {pins, bidir} = '0;
        void'($urandom(32'h2f8e));
        do_reset();
        check_all();
        // reserved bits and read-only places refuse writes
        wr(`IPFS_ADDR_CFG_A, 8'hFF);
        wr(`IPFS_ADDR_BIDIR_MON, 8'hFF);
        wr(`IPFS_ADDR_IN_MON, 8'hFF);
        req.wr = 1'b0;
        cfg_a = 8'h77;
        repeat (5) @(negedge i_clock);
        check_all();
        // random codes and levels; back-to-back writes to both configs
        for (int n = 0; n < 60; n++) begin
            cfg_a = $urandom() & 8'h77;
            cfg_b = $urandom() & 8'h77;
            wr(`IPFS_ADDR_CFG_A, cfg_a[7:0] | 8'h88);
            wr(`IPFS_ADDR_CFG_B, cfg_b[7:0]);
            req.wr = 1'b0;
            pins = 4'($urandom());
            bidir = 1'($urandom());
            bidir_in = 1'($urandom());
            repeat (5) @(negedge i_clock);
            check_all();
        end
        // second reset in mid-run clears every register
        do_reset();
        check_all();
        end_sim();
    end
endmodule
`default_nettype wire
